// ==== logic/smb_core.sv ====
// Purpose: Two-wire serial bus master and slave with byte holding register
// Assumes: mclk 25 MHz; pins are open drain, enable high pulls low
// Notes:   Bus pins pass two flops before any logic looks at them
`timescale 1ns/1ps
`include "smb_defs.svh"

// Overview of operation
// - Follow the management bus protocol, stay compatible with two-wire peers.
// - Software moves whole bytes; hardware sequences every bit itself.
// - Master bit rate never above one twentieth of mclk; as slave it follows the bus clock.
// - Serial clock low phase can be stretched for slower devices.
// - Acts as master, slave or both on a multi-master bus.
// - Drives data, makes and syncs clock, arbitrates, detects and makes START/STOP.
// - Address acceptance by software, or hardware match with automatic acknowledge.
// - One eight-bit holding register: next byte to send or last received.
// - Outgoing bytes leave most significant bit first.
// - First received bit ends in the most significant position.
// - While sending, bus data shifts in, so the last bus byte remains.
// - Lost arbitration turns master sender into slave receiver, byte kept.
// - Mask bits seven to one select which own-address bits are compared.
// - Mask bit zero: zero means software acknowledges, one means hardware does.
// - Own 0x34, mask 0x7E, general call: matches 0x34, 0x35 and zero.
// - Own 0x70, mask 0x73, no general call: matches four addresses.
module smb_core import smb_pkg::*; #(
	parameter int unsigned HALF_CYC = `SMB_HALF_CYC,
	parameter int unsigned FIFO_DEP = `SMB_FIFO_DEP
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_b,
	// Register port
	input  wire smb_sfr_req_t sfr_req,
	output logic [7:0]        sfr_rdata,
	// Serial clock pin
	input  wire logic         scl_i,
	output logic              scl_o,
	output logic              scl_oe,
	// Serial data pin
	input  wire logic         sda_i,
	output logic              sda_o,
	output logic              sda_oe
);
	localparam int PW = $clog2(FIFO_DEP);

	logic [1:0] scl_sync_ff, sda_sync_ff;
	logic       scl_d_ff, sda_d_ff, busy_ff;
	logic       en_ff, sta_ff, sto_ff, ack_out_ff, ack_in_ff, arb_ff, flag_ff;
	logic [7:0] mask_ff, own_ff, hold_data_ff, rdata_ff;
	smb_mst_t   mst_ff, nxt_mst;
	logic [4:0] cnt_ff, nxt_cnt;
	logic       gen_scl_ff, nxt_scl, gen_sda_ff, nxt_sda;
	logic       master_ff, nxt_master;
	logic       act_ff, nxt_act, tx_ff, nxt_tx, aph_ff, nxt_aph;
	logic [3:0] nbit_ff, nxt_nbit;
	logic [7:0] shift_ff, nxt_shift;
	logic       ackd_ff, nxt_ackd, hold_ff, nxt_hold, push_ff, nxt_push;
	logic       doe_ff, nxt_doe, gack_ff, nxt_gack, ackb_ff, nxt_ackb;
	logic       scl_oe_ff, sda_oe_ff, pin_lvl_ff;
	smb_ent_t   fifo_mem [FIFO_DEP];
	logic [PW-1:0] wp_ff, rp_ff;
	logic [PW:0]   fc_ff;

	// Synchronised bus levels and their edges
	wire scl_s     = scl_sync_ff[1];
	wire sda_s     = sda_sync_ff[1];
	wire scl_rise  = scl_s & ~scl_d_ff;
	wire scl_fall  = ~scl_s & scl_d_ff;
	wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

	// Register decode
	wire wr_ctrl = sfr_req.wr && sfr_req.addr == `SMB_ADR_CTRL;
	wire wr_data = sfr_req.wr && sfr_req.addr == `SMB_ADR_DATA;
	wire wr_mask = sfr_req.wr && sfr_req.addr == `SMB_ADR_MASK;
	wire wr_own  = sfr_req.wr && sfr_req.addr == `SMB_ADR_OWN;
	// Enable as it stands after this edge, so one write can enable and start
	wire en_nxt  = wr_ctrl ? sfr_req.wdata[`SMB_CB_EN] : en_ff;
	wire [7:0] ctrl_rd = {en_ff, sta_ff, sto_ff, ack_out_ff,
		ack_in_ff, arb_ff, flag_ff, master_ff};
	wire [7:0] rd_mux =
		(sfr_req.addr == `SMB_ADR_CTRL) ? ctrl_rd :
		(sfr_req.addr == `SMB_ADR_DATA) ? hold_data_ff :
		(sfr_req.addr == `SMB_ADR_MASK) ? mask_ff :
		(sfr_req.addr == `SMB_ADR_OWN)  ? own_ff : 8'h00;

	// Buffer handshakes: filled at byte end, drained into holding register
	wire f_valid = fc_ff != '0;
	wire f_ready = fc_ff != (PW+1)'(FIFO_DEP);
	wire push    = push_ff & f_ready;
	wire pop     = f_valid & ~flag_ff;
	smb_ent_t f_head;
	assign f_head = fifo_mem[rp_ff];

	// Address compare and acknowledge choice
	wire auto_ack = mask_ff[`SMB_MASK_AUTO];
	wire [7:0] adiff = (shift_ff ^ own_ff) & mask_ff & 8'hFE;
	wire gc_hit   = own_ff[`SMB_OWN_GC] && shift_ff[7:1] == 7'h00;
	wire addr_hit = adiff == 8'h00 || gc_hit;
	wire give_ack = auto_ack ? (aph_ff ? addr_hit : 1'b1)
		: ack_out_ff;
	wire half_done = cnt_ff >= 5'(HALF_CYC - 1);
	wire rel = hold_ff & ~push_ff & ~f_valid & ~flag_ff;
	wire arb_ev = scl_rise & act_ff & ~hold_ff & master_ff & tx_ff
		& ~nbit_ff[3] & ~doe_ff & ~sda_s;
	wire fall_go = scl_fall & act_ff & ~hold_ff;
	wire rise_go = scl_rise & act_ff & ~hold_ff;

	// Two flops on each pin before any logic reads it
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_d_ff    <= 1'b1;
			sda_d_ff    <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], scl_i};
			sda_sync_ff <= {sda_sync_ff[0], sda_i};
			scl_d_ff    <= scl_s;
			sda_d_ff    <= sda_s;
		end
	end

	// Control and status; hardware set wins over software clear
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			en_ff <= 1'b0; sta_ff <= 1'b0; sto_ff <= 1'b0;
			ack_out_ff <= 1'b0; ack_in_ff <= 1'b0; arb_ff <= 1'b0;
			flag_ff <= 1'b0; mask_ff <= `SMB_MASK_RST; own_ff <= `SMB_OWN_RST;
			hold_data_ff <= 8'h00; rdata_ff <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				en_ff      <= sfr_req.wdata[`SMB_CB_EN];
				ack_out_ff <= sfr_req.wdata[`SMB_CB_ACKO];
			end
			sta_ff <= en_nxt & ~(master_ff & start_det)
				& (wr_ctrl ? sfr_req.wdata[`SMB_CB_STA] : sta_ff);
			sto_ff <= en_nxt & ~stop_det
				& (wr_ctrl ? sfr_req.wdata[`SMB_CB_STO] : sto_ff);
			arb_ff  <= arb_ev | (arb_ff
				& ~(wr_ctrl & ~sfr_req.wdata[`SMB_CB_ARB]));
			flag_ff <= pop | arb_ev | (flag_ff
				& ~(wr_ctrl & ~sfr_req.wdata[`SMB_CB_FLAG]));
			if (pop)
				ack_in_ff <= f_head.ack;
			if (pop)
				hold_data_ff <= f_head.data;
			else if (wr_data)
				hold_data_ff <= sfr_req.wdata;
			if (wr_mask)
				mask_ff <= sfr_req.wdata;
			if (wr_own)
				own_ff <= sfr_req.wdata;
			if (sfr_req.rd)
				rdata_ff <= rd_mux;
		end
	end

	// Byte buffer; a full buffer keeps the clock held low
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wp_ff <= '0;
			rp_ff <= '0;
			fc_ff <= '0;
		end else begin
			wp_ff <= wp_ff + PW'(push);
			rp_ff <= rp_ff + PW'(pop);
			fc_ff <= fc_ff + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
	always_ff @(posedge mclk) begin
		if (push)
			fifo_mem[wp_ff] <= '{ack: ackb_ff, data: shift_ff};
	end

	// Clock generator: START, bit clock, STOP; half period is the rate cap
	always_comb begin
		nxt_mst = mst_ff;
		nxt_cnt = half_done ? cnt_ff : cnt_ff + 5'h01;
		nxt_scl = gen_scl_ff;
		nxt_sda = gen_sda_ff;
		nxt_master = master_ff;
		unique case (mst_ff)
			M_IDLE: begin
				nxt_cnt = 5'h00;
				if (en_ff && sta_ff && !busy_ff)
					nxt_mst = M_SCLHI;
			end
			M_SETUP: if (half_done) begin
				nxt_scl = 1'b0;
				nxt_mst = M_SCLHI;
				nxt_cnt = 5'h00;
			end
			M_SCLHI: begin
				if (!scl_s)
					nxt_cnt = 5'h00;
				if (scl_s && half_done) begin
					nxt_sda = 1'b1;
					nxt_master = 1'b1;
					nxt_mst = M_STA_LO;
					nxt_cnt = 5'h00;
				end
			end
			M_STA_LO: if (half_done) begin
				nxt_scl = 1'b1;
				nxt_sda = 1'b0;
				nxt_mst = M_RLO;
				nxt_cnt = 5'h00;
			end
			M_RLO: begin
				if (rel && sto_ff) begin
					nxt_sda = 1'b1;
					nxt_mst = M_STP_A;
					nxt_cnt = 5'h00;
				end else if (rel && sta_ff) begin
					nxt_mst = M_SETUP;
					nxt_cnt = 5'h00;
				end else if (rel) begin
					nxt_cnt = 5'h00;
				end else if (half_done && !hold_ff) begin
					nxt_scl = 1'b0;
					nxt_mst = M_RHI;
					nxt_cnt = 5'h00;
				end
			end
			M_RHI: begin
				if (!scl_s)
					nxt_cnt = 5'h00;
				if (scl_s && half_done) begin
					nxt_scl = 1'b1;
					nxt_mst = M_RLO;
					nxt_cnt = 5'h00;
				end
			end
			M_STP_A: if (half_done) begin
				nxt_scl = 1'b0;
				nxt_mst = M_STP_B;
				nxt_cnt = 5'h00;
			end
			M_STP_B: begin
				if (!scl_s)
					nxt_cnt = 5'h00;
				if (scl_s && half_done) begin
					nxt_sda = 1'b0;
					nxt_master = 1'b0;
					nxt_mst = M_IDLE;
				end
			end
		endcase
		// Losing the bus drops every master drive at once
		if (arb_ev || !en_ff) begin
			nxt_mst = M_IDLE;
			nxt_scl = 1'b0;
			nxt_sda = 1'b0;
			nxt_master = 1'b0;
		end
	end

	// Bit engine, shared by both roles, steps on observed clock edges
	always_comb begin
		nxt_act = act_ff; nxt_tx = tx_ff; nxt_aph = aph_ff;
		nxt_nbit = nbit_ff; nxt_shift = shift_ff; nxt_ackd = ackd_ff;
		nxt_hold = hold_ff; nxt_push = push_ff & ~push;
		nxt_doe = doe_ff; nxt_gack = gack_ff; nxt_ackb = ackb_ff;
		if (start_det) begin
			nxt_act = en_ff; nxt_aph = 1'b1; nxt_nbit = 4'h0;
			nxt_ackd = 1'b0; nxt_hold = 1'b0; nxt_doe = 1'b0;
			nxt_tx = master_ff;
			if (master_ff)
				nxt_shift = hold_data_ff;
		end else if (stop_det) begin
			nxt_act = 1'b0; nxt_hold = 1'b0; nxt_doe = 1'b0;
		end else begin
			if (fall_go && ackd_ff) begin
				nxt_ackd = 1'b0; nxt_hold = 1'b1;
				nxt_push = 1'b1; nxt_doe = 1'b0;
			end else if (fall_go && !nbit_ff[3]) begin
				nxt_doe = tx_ff & ~shift_ff[7];
			end else if (fall_go) begin
				nxt_doe  = ~tx_ff & give_ack;
				nxt_gack = give_ack;
			end
			if (rise_go && !nbit_ff[3]) begin
				nxt_shift = {shift_ff[6:0], sda_s};
				nxt_nbit = nbit_ff + 4'h1;
				if (arb_ev) begin
					nxt_tx = 1'b0;
					nxt_doe = 1'b0;
				end
			end else if (rise_go) begin
				nxt_nbit = 4'h0; nxt_ackb = sda_s; nxt_ackd = 1'b1;
				if (!master_ff && (tx_ff ? sda_s : !gack_ff))
					nxt_act = 1'b0;
				if (aph_ff)
					nxt_tx = master_ff ? ~shift_ff[0] : shift_ff[0];
				nxt_aph = 1'b0;
			end
			if (rel) begin
				nxt_hold = 1'b0;
				if (tx_ff && !(master_ff && (sta_ff || sto_ff))) begin
					nxt_shift = hold_data_ff;
					nxt_doe = ~hold_data_ff[7];
				end
			end
		end
		if (!en_ff) begin
			nxt_act = 1'b0; nxt_hold = 1'b0; nxt_doe = 1'b0;
		end
	end

	// State registers and bus busy tracking
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mst_ff <= M_IDLE; cnt_ff <= 5'h00; gen_scl_ff <= 1'b0;
			gen_sda_ff <= 1'b0; master_ff <= 1'b0; busy_ff <= 1'b0;
			act_ff <= 1'b0; tx_ff <= 1'b0; aph_ff <= 1'b0;
			nbit_ff <= 4'h0; shift_ff <= 8'h00; ackd_ff <= 1'b0;
			hold_ff <= 1'b0; push_ff <= 1'b0; doe_ff <= 1'b0;
			gack_ff <= 1'b0; ackb_ff <= 1'b1;
		end else begin
			mst_ff <= nxt_mst; cnt_ff <= nxt_cnt; gen_scl_ff <= nxt_scl;
			gen_sda_ff <= nxt_sda; master_ff <= nxt_master;
			busy_ff <= start_det | (busy_ff & ~stop_det);
			act_ff <= nxt_act; tx_ff <= nxt_tx; aph_ff <= nxt_aph;
			nbit_ff <= nxt_nbit; shift_ff <= nxt_shift; ackd_ff <= nxt_ackd;
			hold_ff <= nxt_hold; push_ff <= nxt_push; doe_ff <= nxt_doe;
			gack_ff <= nxt_gack; ackb_ff <= nxt_ackb;
		end
	end

	// Pin drivers; slave stretches the low phase while it waits
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			scl_oe_ff  <= 1'b0;
			sda_oe_ff  <= 1'b0;
			pin_lvl_ff <= 1'b0;
		end else begin
			scl_oe_ff  <= gen_scl_ff | (hold_ff & act_ff & ~master_ff);
			sda_oe_ff  <= doe_ff | gen_sda_ff;
			pin_lvl_ff <= 1'b0;
		end
	end
	assign scl_oe    = scl_oe_ff;
	assign sda_oe    = sda_oe_ff;
	assign scl_o     = pin_lvl_ff;
	assign sda_o     = pin_lvl_ff;
	assign sfr_rdata = rdata_ff;

	// Checks on the engine and generator
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_MSB_FIRST:
	assert property (fall_go && !ackd_ff && !nbit_ff[3] && tx_ff
		|=> doe_ff == !$past(shift_ff[7])) else $error("bad tx bit");
	AST_RX_SHIFT:
	assert property (rise_go && !nbit_ff[3] && !start_det && !stop_det
		|=> shift_ff[0] == $past(sda_s)) else $error("bad rx bit");
	AST_POP_FLAG:
	assert property (pop |=> flag_ff && hold_data_ff == $past(f_head.data))
		else $error("byte not presented");
	AST_STRETCH:
	assert property (hold_ff && act_ff && !master_ff ##1 hold_ff
		&& act_ff && !master_ff |-> scl_oe_ff) else $error("no stretch");
	AST_ARB_SWITCH:
	assert property (arb_ev && !stop_det && en_ff |=> !master_ff
		&& arb_ff && act_ff && !tx_ff) else $error("arb switch");
	AST_AUTO_ACK:
	assert property (fall_go && nbit_ff[3] && !ackd_ff && !tx_ff
		&& auto_ack && !aph_ff |=> doe_ff) else $error("no auto ack");
	AST_LOW_HALF:
	assert property ($rose(gen_scl_ff) && mst_ff == M_RLO
		|-> (gen_scl_ff || !en_ff)[*8]) else $error("fast clock");
	AST_START_SEQ:
	assert property (mst_ff == M_SCLHI && nxt_mst == M_STA_LO
		|=> gen_sda_ff && !gen_scl_ff ##1 gen_sda_ff)
		else $error("bad start");
	AST_NOMATCH:
	assert property (fall_go && nbit_ff[3] && !ackd_ff && aph_ff
		&& auto_ack && !tx_ff && !addr_hit |=> !doe_ff)
		else $error("acked foreign address");
	COV_MASTER_ADDR: cover property (master_ff && rise_go && nbit_ff[3]);
	COV_SLAVE_HIT: cover property (fall_go && aph_ff && addr_hit
		&& !master_ff);
	COV_ARB: cover property (arb_ev);
	COV_STOP_GEN: cover property (mst_ff == M_STP_B ##1 mst_ff == M_IDLE);
endmodule

// ==== logic/smb_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Register port of eight address bits and eight data bits
// Notes:   Included by its bare name from the serial bus core
`ifndef SMB_DEFS_SVH
`define SMB_DEFS_SVH
`define SMB_ADR_CTRL  8'hC0
`define SMB_ADR_DATA  8'hC2
`define SMB_ADR_MASK  8'hD6
`define SMB_ADR_OWN   8'hD7
`define SMB_MASK_RST  8'hFE
`define SMB_OWN_RST   8'h00
`define SMB_CB_EN     7
`define SMB_CB_STA    6
`define SMB_CB_STO    5
`define SMB_CB_ACKO   4
`define SMB_CB_ARB    2
`define SMB_CB_FLAG   1
`define SMB_OWN_GC    0
`define SMB_MASK_AUTO 0
`define SMB_CLK_NS    40
`define SMB_HALF_NS   400
`define SMB_HALF_CYC  ((`SMB_HALF_NS + `SMB_CLK_NS - 1) / `SMB_CLK_NS)
`define SMB_FIFO_DEP  2
`endif

// ==== logic/smb_pkg.sv ====
// Purpose: Types shared by the serial bus core and its bench
// Assumes: Constants live in smb_defs.svh
// Notes:   Register requests and buffered bytes travel as structs
package smb_pkg;
	// Clock generator states
	typedef enum logic [2:0] {
		M_IDLE   = 3'h0,
		M_SETUP  = 3'h1,
		M_SCLHI  = 3'h2,
		M_STA_LO = 3'h3,
		M_RLO    = 3'h4,
		M_RHI    = 3'h5,
		M_STP_A  = 3'h6,
		M_STP_B  = 3'h7
	} smb_mst_t;
	// One register access, valid for one mclk cycle
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} smb_sfr_req_t;
	// One finished byte and the acknowledge bit seen after it
	typedef struct packed {
		logic       ack;
		logic [7:0] data;
	} smb_ent_t;
endpackage

// ==== tb/smb_peer.sv ====
// Purpose: Behavioural far-side bus device, as master or as slave
// Assumes: Open-drain wires with pull-ups resolved in the bench
// Notes:   Bit timing runs on its own delays, unrelated to mclk
`timescale 1ns/1ps
module smb_peer (
	// Resolved bus levels
	input  wire logic scl,
	input  wire logic sda,
	// Pull requests, high pulls the wire low
	output logic      scl_pull,
	output logic      sda_pull
);
	localparam int HALF = 160;

	// Idle with both lines released
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	// Master START: data falls while clock is high
	task automatic start();
		sda_pull = 1'b1;
		#HALF scl_pull = 1'b1;
	endtask

	// One clock pulse; a low held by the device is waited out
	task automatic pulse(input int lo, output logic s);
		#lo scl_pull = 1'b0;
		wait (scl);
		#(HALF / 2) s = sda;
		#(HALF / 2) scl_pull = 1'b1;
	endtask

	// Byte out, top bit first; long low in the ack slot for the reply
	task automatic send(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			sda_pull = !v[i];
			pulse(HALF, s);
		end
		sda_pull = 1'b0;
		pulse(3 * HALF, ack);
	endtask

	// Master STOP: data rises while clock is high
	task automatic stop();
		sda_pull = 1'b1;
		#HALF scl_pull = 1'b0;
		wait (scl);
		#HALF sda_pull = 1'b0;
	endtask

	// Slave: wait for START, take eight bits on rising clock, then ACK
	task automatic recv(output logic [7:0] v);
		@(negedge sda iff scl);
		repeat (8) @(posedge scl) v = {v[6:0], sda};
		@(negedge scl) #40 sda_pull = 1'b1;
		@(negedge scl) #40 sda_pull = 1'b0;
	endtask
endmodule

// ==== tb/test_smb_core.sv ====
// Purpose: Self-checking bench for the two-wire serial bus core
// Assumes: Peer model on the far side; registers through sfr_req
// Notes:   Peer timing is free running, so syncs see any phase
`timescale 1ns/1ps
`include "smb_defs.svh"
module test_smb_core import smb_pkg::*;;
	logic         mclk;
	logic         rst_b;
	smb_sfr_req_t req;
	logic [7:0]   rdata;
	logic         scl_oe;
	logic         sda_oe;
	logic         scl_lvl;
	logic         sda_lvl;
	logic         p_scl;
	logic         p_sda;
	int           n_fail;
	int           total_checks;

	// Pull-ups: a wire is high unless some party pulls it
	wire scl = !(scl_oe || p_scl);
	wire sda = !(sda_oe || p_sda);

	smb_core smb_core_inst (
		.mclk(mclk), .rst_b(rst_b), .sfr_req(req), .sfr_rdata(rdata),
		.scl_i(scl), .scl_o(scl_lvl), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_lvl), .sda_oe(sda_oe));
	smb_peer smb_peer_inst (
		.scl(scl), .sda(sda), .scl_pull(p_scl), .sda_pull(p_sda));

	// 25 MHz system clock
	always #20 mclk = !mclk;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Register strobes last exactly one cycle
	task automatic wr(input logic [7:0] a, d);
		@(posedge mclk) req <= '{1'b1, 1'b0, a, d};
		@(posedge mclk) req <= '0;
	endtask

	// Sampled mid-cycle, clear of the update edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge mclk) req <= '0;
		@(posedge mclk);
		@(negedge mclk) v = rdata;
	endtask

	// Poll the event flag, bounded so a dead engine cannot hang us
	task automatic wait_flag(output logic [7:0] c);
		int k;
		k = 0;
		c = 8'h00;
		while (!c[`SMB_CB_FLAG] && k < 400) begin
			rd(`SMB_ADR_CTRL, c);
			k++;
		end
	endtask

	// Reset values, read-write place, unmapped place
	task automatic t_regs();
		logic [7:0] v;
		chk("pin levels", {6'h00, scl_lvl, sda_lvl}, 8'h00);
		rd(`SMB_ADR_MASK, v);
		chk("mask reset", v, `SMB_MASK_RST);
		rd(`SMB_ADR_CTRL, v);
		chk("ctrl reset", v, 8'h00);
		rd(`SMB_ADR_DATA, v);
		chk("data reset", v, 8'h00);
		rd(`SMB_ADR_OWN, v);
		chk("own reset", v, `SMB_OWN_RST);
		wr(`SMB_ADR_MASK, 8'h5B);
		rd(`SMB_ADR_MASK, v);
		chk("mask rw", v, 8'h5B);
		wr(8'hC5, 8'hFF);
		rd(8'hC5, v);
		chk("unmapped", v, 8'h00);
	endtask

	// Device as master sends one address byte to the peer slave
	task automatic t_master();
		logic [7:0] v;
		logic [7:0] c;
		wr(`SMB_ADR_DATA, 8'hA6);
		wr(`SMB_ADR_CTRL, 8'hC0);
		fork
			smb_peer_inst.recv(v);
			wait_flag(c);
		join
		chk("wire byte", v, 8'hA6);
		chk("ctrl after byte", c & 8'h0B, 8'h03);
		rd(`SMB_ADR_DATA, v);
		chk("data seen", v, 8'hA6);
		repeat (40) @(posedge mclk);
		chk("scl held", {7'h00, scl}, 8'h00);
		wr(`SMB_ADR_CTRL, 8'hA0);
		repeat (60) @(posedge mclk);
		chk("bus free", {6'h00, scl, sda}, 8'h03);
	endtask

	// Peer master offers one address; ex says if it is taken
	task automatic addr(input logic [6:0] a, input logic ex, fchk);
		logic       ack;
		logic [7:0] c;
		smb_peer_inst.start();
		smb_peer_inst.send({a, 1'b0}, ack);
		chk("ack", {7'h00, ack}, {7'h00, !ex});
		repeat (8) @(posedge mclk);
		rd(`SMB_ADR_CTRL, c);
		if (fchk) begin
			chk("flag", c & 8'h02, ex ? 8'h02 : 8'h00);
		end
		if (ex) begin
			rd(`SMB_ADR_DATA, c);
			chk("addr byte", c, {a, 1'b0});
		end
		wr(`SMB_ADR_CTRL, 8'h80);
		smb_peer_inst.stop();
		repeat (20) @(posedge mclk);
	endtask

	// Hardware match in both example setups, then software ack
	task automatic t_slave();
		wr(`SMB_ADR_CTRL, 8'h80);
		wr(`SMB_ADR_OWN, {7'h34, 1'b1});
		wr(`SMB_ADR_MASK, {7'h7E, 1'b1});
		addr(7'h34, 1'b1, 1'b1);
		addr(7'h35, 1'b1, 1'b1);
		addr(7'h00, 1'b1, 1'b1);
		addr(7'h36, 1'b0, 1'b1);
		wr(`SMB_ADR_OWN, {7'h70, 1'b0});
		wr(`SMB_ADR_MASK, {7'h73, 1'b1});
		for (int i = 0; i < 4; i++) begin
			addr(7'h70 + 7'(i * 4), 1'b1, 1'b1);
		end
		addr(7'h71, 1'b0, 1'b1);
		addr(7'h00, 1'b0, 1'b1);
		wr(`SMB_ADR_MASK, 8'hFE);
		wr(`SMB_ADR_CTRL, 8'h90);
		addr(7'h2B, 1'b1, 1'b1);
		wr(`SMB_ADR_CTRL, 8'h80);
		addr(7'h2B, 1'b0, 1'b0);
	endtask

	// Main sequence: reset for eight cycles, then the scenarios
	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		req = '0;
		n_fail = 0;
		total_checks = 0;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		t_regs();
		t_master();
		t_slave();
		finish_test();
	end

	// Watchdog, well past the expected run of about 100 us
	initial begin
		#400000;
		n_fail++;
		finish_test();
	end
endmodule
